// [scc_unit.sv]
// Contract
// - Immediate policy applies edits at once
// - Deferred policy applies at zeroing or power-up
// - Multiplier range -99999..999999, zero rejected
// - Divisor 1..999999, never zero, precounter modulus
// - Offset range -99999..999999 added to result
// - Shown = main*mul + pre*mul/div + offset
// - Precounter holds fraction, main holds integer
// - Fixed point, fractions truncated downward
// - Station number 0..199, answer matching frames
// - Station zero answers address 255
// - Eight line rates 1200 to 115200
// - Permit gates remote config writes
// - Registers 04h..08h always writable
// - Frame gap watch 0..99 s, 0 off
// - Default answer delay is none
// - Optional 10/20/50/100/200 character delay
// - Passcode 0000 means no protection
// - Recovery code works once, clears passcode
// - Per-threshold edit permit bypasses passcode
// - Offset edit permit bypasses passcode
// - Restore needs 5465 then confirm
// - Serve functions 03h, 06h, 10h
`timescale 1ns/100ps
`default_nettype none
module scc_unit #(
  parameter int THRESHOLDS = 4
) (
  input  wire logic                  clk,
  input  wire logic                  reset_n,
  input  wire logic                  apply_on_zeroing,
  input  wire logic                  zero_event,
  input  wire logic                  cfg_we,
  input  wire logic [31:0]           cfg_mul,
  input  wire logic [31:0]           cfg_div,
  input  wire logic [31:0]           cfg_ofs,
  input  wire logic [2:0]            cfg_point,
  input  wire logic                  pulse_up,
  input  wire logic                  pulse_dn,
  input  wire logic [7:0]            station_in,
  input  wire logic                  station_we,
  input  wire logic [2:0]            rate_sel,
  input  wire logic                  remote_config_write_permit,
  input  wire logic [6:0]            frame_gap_watch,
  input  wire logic [2:0]            answer_delay,
  input  wire logic                  frame_seen,
  input  wire logic [7:0]            frame_addr,
  input  wire logic [7:0]            frame_func,
  input  wire logic [7:0]            frame_reg,
  input  wire logic                  frame_is_write,
  input  wire logic                  request_done,
  input  wire logic                  passcode_we,
  input  wire logic [15:0]           user_passcode_in,
  input  wire logic                  code_entered,
  input  wire logic [15:0]           code_value,
  input  wire logic [15:0]           recovery_code,
  input  wire logic [THRESHOLDS-1:0] threshold_edit_permit,
  input  wire logic                  offset_edit_permit,
  input  wire logic                  restore_confirm,
  input  wire logic                  restore_cancel,
  output logic signed [47:0]         shown_value,
  output logic [2:0]                 point_active,
  output logic [31:0]                pre_count,
  output logic signed [31:0]         main_count,
  output logic                       cfg_rejected,
  output logic [7:0]                 station,
  output logic [2:0]                 line_rate,
  output logic                       frame_accept,
  output logic                       write_accept,
  output logic                       gap_timeout,
  output logic                       answer_go,
  output logic [15:0]                user_passcode,
  output logic                       recovery_used,
  output logic                       unlocked,
  output logic [THRESHOLDS-1:0]      threshold_edit_ok,
  output logic                       offset_edit_ok,
  output logic                       factory_restore
);
  // ----------------------------------------
  // Scaling configuration
  // ----------------------------------------
  logic signed [31:0] mul_pend, ofs_pend, mul_act, ofs_act;
  logic [31:0]        div_pend, div_act;
  logic [2:0]         point_pend;
  logic               cfg_ok;
  always_comb begin
    cfg_ok = ($signed(cfg_mul) >= $signed(scc_pkg::MUL_MIN))
           && ($signed(cfg_mul) <= $signed(scc_pkg::VAL_MAX))
           && (cfg_mul != 32'h00000000)
           && (cfg_div >= scc_pkg::DIV_MIN) && (cfg_div <= scc_pkg::VAL_MAX)
           && ($signed(cfg_ofs) >= $signed(scc_pkg::MUL_MIN))
           && ($signed(cfg_ofs) <= $signed(scc_pkg::VAL_MAX));
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      mul_pend   <= scc_pkg::MUL_RESET;
      div_pend   <= scc_pkg::DIV_RESET;
      ofs_pend   <= scc_pkg::OFS_RESET;
      point_pend <= scc_pkg::POINT_RESET;
      cfg_rejected <= 1'b0;
    end else begin
      cfg_rejected <= cfg_we && !cfg_ok;
      if (cfg_we && cfg_ok) begin
        mul_pend   <= cfg_mul;
        div_pend   <= cfg_div;
        ofs_pend   <= cfg_ofs;
        point_pend <= cfg_point;
      end
    end
  end

  // Power-up copies reset values into both copies, so it acts as an apply
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      mul_act      <= scc_pkg::MUL_RESET;
      div_act      <= scc_pkg::DIV_RESET;
      ofs_act      <= scc_pkg::OFS_RESET;
      point_active <= scc_pkg::POINT_RESET;
    end else if (!apply_on_zeroing || zero_event) begin
      mul_act      <= mul_pend;
      div_act      <= div_pend;
      ofs_act      <= ofs_pend;
      point_active <= point_pend;
    end
  end

  // ----------------------------------------
  // Precounter and main counter
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n || zero_event) begin
      pre_count  <= 32'h00000000;
      main_count <= 32'sh00000000;
    end else if (pulse_up && !pulse_dn) begin
      if (pre_count + 32'h00000001 >= div_act) begin
        pre_count  <= 32'h00000000;
        main_count <= main_count + 32'sh00000001;
      end else begin
        pre_count <= pre_count + 32'h00000001;
      end
    end else if (pulse_dn && !pulse_up) begin
      if (pre_count == 32'h00000000) begin
        pre_count  <= div_act - 32'h00000001;
        main_count <= main_count - 32'sh00000001;
      end else begin
        pre_count <= pre_count - 32'h00000001;
      end
    end
  end

  // ----------------------------------------
  // Result; slow combinational divide, multicycle as inputs rarely change
  // ----------------------------------------
  logic signed [63:0] frac_num, frac_q, whole;
  always_comb begin
    frac_num = $signed({32'h00000000, pre_count}) * $signed({{32{mul_act[31]}}, mul_act});
    frac_q   = frac_num / $signed({32'h00000000, div_act});
    if (frac_num < 0 && (frac_q * $signed({32'h00000000, div_act})) != frac_num)
      frac_q = frac_q - 64'sh1;
    whole = $signed({{32{main_count[31]}}, main_count})
          * $signed({{32{mul_act[31]}}, mul_act});
  end
  always_ff @(posedge clk) begin
    if (!reset_n) shown_value <= 48'sh0;
    else shown_value <= 48'(whole + frac_q + $signed({{32{ofs_act[31]}}, ofs_act}));
  end

  // ----------------------------------------
  // Bus slave settings
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      station   <= scc_pkg::STATION_RESET;
      line_rate <= scc_pkg::RATE_RESET;
    end else begin
      if (station_we && station_in <= scc_pkg::STATION_MAX) station <= station_in;
      line_rate <= rate_sel;
    end
  end

  logic addr_hit, func_ok, reg_open;
  always_comb begin
    addr_hit = (station == 8'h00) ? (frame_addr == scc_pkg::STATION_BCAST)
                                  : (frame_addr == station);
    func_ok  = frame_func == scc_pkg::FN_READ || frame_func == scc_pkg::FN_WRITE_ONE
            || frame_func == scc_pkg::FN_WRITE_MANY;
    reg_open = frame_reg >= scc_pkg::REG_OPEN_LO && frame_reg <= scc_pkg::REG_OPEN_HI;
  end
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      frame_accept <= 1'b0;
      write_accept <= 1'b0;
    end else begin
      frame_accept <= frame_seen && addr_hit && func_ok;
      write_accept <= frame_seen && addr_hit && frame_is_write && func_ok
                   && (remote_config_write_permit || reg_open);
    end
  end

  // Character time: baud divider per rate select
  logic [31:0] char_cycles;
  always_comb begin
    case (line_rate)
      3'h0:    char_cycles = 32'(scc_pkg::CLK_HZ / 1200 * scc_pkg::BITS_PER_CHAR);
      3'h1:    char_cycles = 32'(scc_pkg::CLK_HZ / 2400 * scc_pkg::BITS_PER_CHAR);
      3'h2:    char_cycles = 32'(scc_pkg::CLK_HZ / 4800 * scc_pkg::BITS_PER_CHAR);
      3'h3:    char_cycles = 32'(scc_pkg::CLK_HZ / 9600 * scc_pkg::BITS_PER_CHAR);
      3'h4:    char_cycles = 32'(scc_pkg::CLK_HZ / 19200 * scc_pkg::BITS_PER_CHAR);
      3'h5:    char_cycles = 32'(scc_pkg::CLK_HZ / 38400 * scc_pkg::BITS_PER_CHAR);
      3'h6:    char_cycles = 32'(scc_pkg::CLK_HZ / 57600 * scc_pkg::BITS_PER_CHAR);
      default: char_cycles = 32'(scc_pkg::CLK_HZ / 115200 * scc_pkg::BITS_PER_CHAR);
    endcase
  end
  logic [7:0] delay_chars;
  always_comb begin
    case (answer_delay)
      3'h1:    delay_chars = 8'h0a;
      3'h2:    delay_chars = 8'h14;
      3'h3:    delay_chars = 8'h32;
      3'h4:    delay_chars = 8'h64;
      3'h5:    delay_chars = 8'hc8;
      default: delay_chars = 8'h00;
    endcase
  end

  logic        wait_on;
  logic [31:0] char_tick;
  logic [7:0]  chars_left;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wait_on <= 1'b0; char_tick <= 32'h0; chars_left <= 8'h0; answer_go <= 1'b0;
    end else begin
      answer_go <= 1'b0;
      if (request_done && !wait_on) begin
        if (delay_chars == 8'h00) answer_go <= 1'b1;
        else begin
          wait_on <= 1'b1; chars_left <= delay_chars; char_tick <= char_cycles;
        end
      end else if (wait_on) begin
        if (char_tick > 32'h1) char_tick <= char_tick - 32'h1;
        else if (chars_left == 8'h01) begin
          wait_on <= 1'b0; answer_go <= 1'b1;
        end else begin
          chars_left <= chars_left - 8'h01; char_tick <= char_cycles;
        end
      end
    end
  end

  // Gap watch with a one-second enable pulse
  logic [31:0] sec_div;
  logic [6:0]  gap_s;
  always_ff @(posedge clk) begin
    if (!reset_n || frame_seen) begin
      sec_div <= 32'h0; gap_s <= 7'h0; gap_timeout <= 1'b0;
    end else if (frame_gap_watch == 7'h00) begin
      gap_timeout <= 1'b0;
    end else if (sec_div == scc_pkg::S_PER_CYC_DIV - 32'h1) begin
      sec_div <= 32'h0;
      if (gap_s < scc_pkg::GAP_MAX_S) gap_s <= gap_s + 7'h01;
      if (gap_s + 7'h01 >= frame_gap_watch) gap_timeout <= 1'b1;
    end else sec_div <= sec_div + 32'h1;
  end

  // ----------------------------------------
  // Security
  // ----------------------------------------
  scc_pkg::scc_rst_t rst_state;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      user_passcode <= scc_pkg::PASS_NONE; recovery_used <= 1'b0; unlocked <= 1'b0;
    end else begin
      if (passcode_we) user_passcode <= user_passcode_in;
      if (code_entered) begin
        if (!recovery_used && code_value == recovery_code) begin
          user_passcode <= scc_pkg::PASS_NONE; recovery_used <= 1'b1; unlocked <= 1'b1;
        end else unlocked <= code_value == user_passcode;
      end
      if (user_passcode == scc_pkg::PASS_NONE) unlocked <= 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      threshold_edit_ok <= '0; offset_edit_ok <= 1'b0;
    end else begin
      threshold_edit_ok <= threshold_edit_permit | {THRESHOLDS{unlocked}};
      offset_edit_ok    <= offset_edit_permit || unlocked;
    end
  end
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rst_state <= scc_pkg::SCC_R_IDLE; factory_restore <= 1'b0;
    end else begin
      factory_restore <= 1'b0;
      case (rst_state)
        scc_pkg::SCC_R_IDLE:
          if (code_entered && code_value == scc_pkg::RESTORE_CODE)
            rst_state <= scc_pkg::SCC_R_CODE;
        scc_pkg::SCC_R_CODE:
          if (restore_cancel) rst_state <= scc_pkg::SCC_R_IDLE;
          else if (restore_confirm) begin
            factory_restore <= 1'b1; rst_state <= scc_pkg::SCC_R_IDLE;
          end
        default: rst_state <= scc_pkg::SCC_R_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_div_nonzero: assert property (@(posedge clk) disable iff (!reset_n) div_act != 32'h0)
    else $error("divisor zero");
  a_mul_nonzero: assert property (@(posedge clk) disable iff (!reset_n) mul_act != 32'h0)
    else $error("multiplier zero");
  a_pre_modulo: assert property (@(posedge clk) disable iff (!reset_n) pre_count < div_act)
    else $error("precounter out of range");
  a_defer_hold: assert property (@(posedge clk) disable iff (!reset_n)
    (apply_on_zeroing && !zero_event) |=> $stable(mul_act))
    else $error("deferred apply leaked");
  a_immed_apply: assert property (@(posedge clk) disable iff (!reset_n)
    !apply_on_zeroing |=> mul_act == $past(mul_pend))
    else $error("immediate apply missed");
  a_addr_zero: assert property (@(posedge clk) disable iff (!reset_n)
    (frame_seen && station == 8'h00 && frame_addr == 8'h00) |=> !frame_accept)
    else $error("station zero answered");
  a_write_gate: assert property (@(posedge clk) disable iff (!reset_n)
    (!remote_config_write_permit && frame_reg > scc_pkg::REG_OPEN_HI) |=> !write_accept)
    else $error("write not refused");
  a_restore_cancel: assert property (@(posedge clk) disable iff (!reset_n)
    (rst_state == scc_pkg::SCC_R_CODE && restore_cancel) |=> !factory_restore)
    else $error("cancel restored");
  a_recovery_once: assert property (@(posedge clk) disable iff (!reset_n)
    recovery_used |=> recovery_used)
    else $error("recovery revived");
endmodule // scc_unit
`default_nettype wire

// [scc_pkg.sv]
`default_nettype none
package scc_pkg;
  // ----------------------------------------
  // Value ranges
  // ----------------------------------------
  localparam int         VAL_W        = 32;
  localparam int         CNT_W        = 48;
  localparam logic [31:0] MUL_MIN     = 32'hfffe7961; // -99999
  localparam logic [31:0] VAL_MAX     = 32'h000f423f; // 999999
  localparam logic [31:0] DIV_MIN     = 32'h00000001;
  localparam logic [31:0] MUL_RESET   = 32'h00000001;
  localparam logic [31:0] DIV_RESET   = 32'h00000001;
  localparam logic [31:0] OFS_RESET   = 32'h00000000;
  localparam logic [2:0]  POINT_RESET = 3'h0;
  // ----------------------------------------
  // Bus settings
  // ----------------------------------------
  localparam logic [7:0]  STATION_MAX   = 8'hc7; // 199
  localparam logic [7:0]  STATION_BCAST = 8'hff;
  localparam logic [7:0]  STATION_RESET = 8'h01;
  localparam logic [2:0]  RATE_RESET    = 3'h3; // 9600 bit/s
  localparam logic [7:0]  FN_READ       = 8'h03;
  localparam logic [7:0]  FN_WRITE_ONE  = 8'h06;
  localparam logic [7:0]  FN_WRITE_MANY = 8'h10;
  localparam logic [7:0]  REG_OPEN_LO   = 8'h04;
  localparam logic [7:0]  REG_OPEN_HI   = 8'h08;
  localparam logic [6:0]  GAP_MAX_S     = 7'h63; // 99 s
  localparam int          CLK_HZ        = 200_000_000;
  localparam int          BITS_PER_CHAR = 11;
  localparam logic [15:0] PASS_NONE     = 16'h0000;
  localparam logic [15:0] RESTORE_CODE  = 16'h5465;
  localparam logic [31:0] S_PER_CYC_DIV = 32'd200_000_000;
  typedef enum logic [1:0] {SCC_R_IDLE = 2'b00, SCC_R_CODE = 2'b01} scc_rst_t;
endpackage
`default_nettype wire

// [scc_master_model.sv]
`timescale 1ns/100ps
`default_nettype none
module scc_master_model (
  input  wire logic       clk,
  output logic            frame_seen,
  output logic [7:0]      frame_addr,
  output logic [7:0]      frame_func,
  output logic [7:0]      frame_reg,
  output logic            frame_is_write,
  output logic            request_done
);
  initial begin
    {frame_seen, frame_addr, frame_func, frame_reg, frame_is_write, request_done} = '0;
  end
  // Released fields turn to their inverse so stale values never look valid
  task automatic send(input logic [7:0] a, input logic [7:0] f, input logic [7:0] r);
    @(negedge clk);
    {frame_seen, frame_addr, frame_func, frame_reg} = {1'b1, a, f, r};
    frame_is_write = (f != scc_pkg::FN_READ);
    @(negedge clk);
    {frame_seen, frame_addr, frame_func, frame_reg} = {1'b0, ~a, ~f, ~r};
    frame_is_write = ~frame_is_write;
  endtask
  task automatic ask_answer();
    @(negedge clk);
    request_done = 1'b1;
    @(negedge clk);
    request_done = 1'b0;
  endtask
endmodule // scc_master_model
`default_nettype wire

// [testbench.sv]
`timescale 1ns/100ps
`default_nettype none
module testbench;
  localparam int TH = 4;
  logic clk, reset_n, apply_on_zeroing, zero_event, cfg_we, pulse_up, pulse_dn, station_we;
  logic remote_config_write_permit, passcode_we, code_entered, offset_edit_permit;
  logic restore_confirm, restore_cancel, frame_seen, frame_is_write, request_done;
  logic [31:0] cfg_mul, cfg_div, cfg_ofs, pre_count;
  logic [2:0] cfg_point, rate_sel, answer_delay, point_active, line_rate;
  logic [7:0] station_in, frame_addr, frame_func, frame_reg, station;
  logic [6:0] frame_gap_watch;
  logic [15:0] user_passcode_in, code_value, recovery_code, user_passcode;
  logic [TH-1:0] threshold_edit_permit, threshold_edit_ok;
  logic signed [47:0] shown_value;
  logic signed [31:0] main_count;
  logic cfg_rejected, frame_accept, write_accept, gap_timeout, answer_go;
  logic recovery_used, unlocked, offset_edit_ok, factory_restore;
  logic [4:0] seen;
  int n_fail, n_compared;

  scc_unit #(.THRESHOLDS(TH)) uut (.*);
  scc_master_model master (.*);

  initial clk = 1'b0;
  always #2.5 clk = ~clk;
  // Sticky capture so one-cycle pulses are never missed between samples
  always @(posedge clk) seen <= seen | {factory_restore, answer_go, write_accept, frame_accept,
                                        cfg_rejected};
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic final_report();
    $display("Compared %0d, errors %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic pulse(input int i, input logic e, input string nm);
    int k;
    for (k = 0; k < 8 && !seen[i]; k++) @(negedge clk);
    n_compared++;
    if (seen[i] !== e) begin
      n_fail++;
      $display("Error %s expected %b seen %b", nm, e, seen[i]);
      if (e) final_report();
    end
    seen = '0;
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic do_reset();
    @(negedge clk);
    reset_n = 1'b0;
    wt(4);
    reset_n = 1'b1;
  endtask
  task automatic cfg(input logic [31:0] m, input logic [31:0] d, input logic [31:0] o);
    @(negedge clk);
    seen = '0;
    {cfg_we, cfg_mul, cfg_div, cfg_ofs} = {1'b1, m, d, o};
    @(negedge clk);
    cfg_we = 1'b0;
  endtask
  task automatic count(input int n, input logic up);
    @(negedge clk);
    {pulse_up, pulse_dn} = {up, !up};
    wt(n);
    {pulse_up, pulse_dn} = 2'b00;
    wt(3);
  endtask
  task automatic frame(input logic [7:0] a, input logic [7:0] f, input logic [7:0] r);
    seen = '0;
    master.send(a, f, r);
  endtask
  task automatic stn(input logic [7:0] v);
    @(negedge clk);
    {station_we, station_in} = {1'b1, v};
    @(negedge clk);
    station_we = 1'b0;
    wt(1);
  endtask
  task automatic pass(input logic [15:0] v);
    @(negedge clk);
    {passcode_we, user_passcode_in} = {1'b1, v};
    @(negedge clk);
    passcode_we = 1'b0;
    wt(2);
  endtask
  task automatic code(input logic [15:0] v);
    @(negedge clk);
    {code_entered, code_value} = {1'b1, v};
    @(negedge clk);
    {code_entered, code_value} = {1'b0, ~v};
  endtask
  task automatic rs(input logic c);
    @(negedge clk);
    {restore_confirm, restore_cancel} = {c, !c};
    @(negedge clk);
    {restore_confirm, restore_cancel} = 2'b00;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    do_reset();
    chk("station", 48'h1, station);
    chk("line_rate", 48'h3, line_rate);
    chk("shown_value", 48'h0, shown_value);
    chk("recovery_used", 48'h0, recovery_used);
    wt(2);
    chk("unlocked", 48'h1, unlocked);
  endtask
  task automatic t_immediate();
    cfg_point = 3'h2;
    cfg(32'h3, 32'h4, 32'h5);
    wt(3);
    chk("point_active", 48'h2, point_active);
    count(7, 1'b1);
    chk("pre_count", 48'h3, pre_count);
    chk("main_count", 48'h1, main_count);
    chk("shown_value", 48'd10, shown_value);
    count(1, 1'b0);
    chk("shown_value", 48'd9, shown_value);
  endtask
  task automatic t_reject();
    logic [31:0] rj [5][3] = '{'{32'h0, 32'h4, 32'h5}, '{32'hfffe7960, 32'h4, 32'h5},
      '{32'h3, 32'h0, 32'h5}, '{32'h3, 32'h000f4240, 32'h5}, '{32'h3, 32'h4, 32'h000f4240}};
    int i;
    for (i = 0; i < 5; i++) begin
      cfg(rj[i][0], rj[i][1], rj[i][2]);
      pulse(0, 1'b1, "cfg_rejected");
    end
    wt(3);
    chk("shown_value", 48'd9, shown_value);
    cfg(scc_pkg::VAL_MAX, scc_pkg::VAL_MAX, scc_pkg::MUL_MIN);
    pulse(0, 1'b0, "cfg_rejected");
    chk("shown_value", 48'd900002, shown_value);
    cfg(32'h3, 32'h4, 32'h5);
    wt(3);
  endtask
  task automatic t_deferred();
    apply_on_zeroing = 1'b1;
    cfg(32'h2, 32'h1, 32'h7);
    wt(4);
    chk("shown_value", 48'd9, shown_value);
    zero_event = 1'b1;
    @(negedge clk);
    zero_event = 1'b0;
    wt(3);
    chk("main_count", 48'h0, main_count);
    chk("shown_value", 48'd7, shown_value);
    count(3, 1'b1);
    chk("main_count", 48'h3, main_count);
    chk("pre_count", 48'h0, pre_count);
    chk("shown_value", 48'd13, shown_value);
    apply_on_zeroing = 1'b0;
  endtask
  task automatic t_station();
    int i;
    stn(8'd200);
    chk("station", 48'h1, station);
    stn(8'd17);
    chk("station", 48'd17, station);
    frame(8'd17, scc_pkg::FN_READ, 8'h00);
    pulse(1, 1'b1, "frame_accept");
    frame(8'd18, scc_pkg::FN_READ, 8'h00);
    pulse(1, 1'b0, "frame_accept");
    stn(8'h00);
    frame(8'hff, scc_pkg::FN_READ, 8'h00);
    pulse(1, 1'b1, "frame_accept");
    frame(8'h00, scc_pkg::FN_READ, 8'h00);
    pulse(1, 1'b0, "frame_accept");
    frame(8'hff, 8'h05, 8'h00);
    pulse(1, 1'b0, "frame_accept");
    for (i = 0; i < 8; i++) begin
      rate_sel = i[2:0];
      wt(2);
      chk("line_rate", 48'(i), line_rate);
    end
  endtask
  task automatic t_permit();
    int r;
    remote_config_write_permit = 1'b0;
    frame(8'hff, scc_pkg::FN_WRITE_ONE, 8'h20);
    pulse(2, 1'b0, "write_accept");
    frame(8'hff, scc_pkg::FN_WRITE_ONE, 8'h03);
    pulse(2, 1'b0, "write_accept");
    for (r = 4; r <= 8; r++) begin
      frame(8'hff, scc_pkg::FN_WRITE_ONE, 8'(r));
      pulse(2, 1'b1, "write_accept");
    end
    frame(8'hff, scc_pkg::FN_WRITE_MANY, 8'h08);
    pulse(2, 1'b1, "write_accept");
    frame(8'hff, scc_pkg::FN_READ, 8'h01);
    pulse(1, 1'b1, "frame_accept");
    remote_config_write_permit = 1'b1;
    frame(8'hff, scc_pkg::FN_WRITE_MANY, 8'h20);
    pulse(2, 1'b1, "write_accept");
  endtask
  task automatic t_answer();
    seen = '0;
    master.ask_answer();
    pulse(3, 1'b1, "answer_go");
    wt(20);
    chk("gap_timeout", 48'h0, gap_timeout);
    code(16'h5465);
    rs(1'b1);
    pulse(4, 1'b1, "factory_restore");
    code(16'h5465);
    rs(1'b0);
    rs(1'b1);
    pulse(4, 1'b0, "factory_restore");
  endtask
  task automatic t_passcode();
    pass(16'h1234);
    code(16'h1111);
    threshold_edit_permit = 4'h5;
    offset_edit_permit = 1'b1;
    wt(2);
    chk("unlocked", 48'h0, unlocked);
    chk("threshold_edit_ok", 48'h5, threshold_edit_ok);
    chk("offset_edit_ok", 48'h1, offset_edit_ok);
    threshold_edit_permit = 4'ha;
    offset_edit_permit = 1'b0;
    wt(2);
    chk("threshold_edit_ok", 48'ha, threshold_edit_ok);
    chk("offset_edit_ok", 48'h0, offset_edit_ok);
    recovery_code = 16'h9876;
    code(16'h9876);
    wt(2);
    chk("user_passcode", 48'h0, user_passcode);
    chk("recovery_used", 48'h1, recovery_used);
    pass(16'h1234);
    code(16'h9876);
    wt(2);
    chk("user_passcode", 48'h1234, user_passcode);
    chk("unlocked", 48'h0, unlocked);
  endtask
  task automatic t_delay();
    answer_delay = 3'h1;
    seen = '0;
    master.ask_answer();
    wt(2000);
    chk("answer_go", 48'h0, seen[3]);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {reset_n, apply_on_zeroing, zero_event, cfg_we, pulse_up, pulse_dn, station_we} = '0;
    {passcode_we, code_entered, restore_confirm, restore_cancel, offset_edit_permit} = '0;
    {cfg_mul, cfg_ofs, station_in, frame_gap_watch, user_passcode_in, code_value} = '0;
    {recovery_code, threshold_edit_permit, cfg_point, remote_config_write_permit} = '0;
    answer_delay = 3'h0;
    {cfg_div, rate_sel, seen, n_fail, n_compared} = {32'h1, 3'h3, 5'h0, 32'h0, 32'h0};
    t_reset();
    t_immediate();
    t_reject();
    t_deferred();
    t_station();
    t_permit();
    t_answer();
    t_passcode();
    t_delay();
    final_report();
  end
endmodule // testbench
`default_nettype wire
